/* hw/pig_irq_gen.sv */
// legacy and vector interrupt generation for a two-function endpoint
// assumes application, config and memory requests all run on i_core_clk
`timescale 1ns/10ps
`include "pig_regs.svh"

module pig_irq_gen (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // legacy interrupt and per-function interrupt control state
    input wire logic i_legacy_irq_level_in,
    input wire logic i_legacy_irq_function_select,
    output logic [`PIG_NUM_PF-1:0] o_intx_disable,
    output logic o_intx_assert,
    output logic o_intx_deassert,
    output logic [`PIG_NUM_PF-1:0] o_msix_enable,
    output logic [`PIG_NUM_PF-1:0] o_msix_fn_mask,
    // config space access
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic i_cfg_func,
    input wire logic [11:0] i_cfg_addr,
    input wire logic [31:0] i_cfg_wdata,
    output logic [31:0] o_cfg_rdata,
    // memory space access
    input wire logic i_mem_wr,
    input wire logic i_mem_rd,
    input wire logic [2:0] i_mem_bar,
    input wire logic [12:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    output logic [31:0] o_mem_rdata,
    output logic o_mem_rvalid,
    // vector interrupt request
    input wire logic i_vector_irq_req,
    input wire logic [`PIG_VEC_W-1:0] i_vector_irq_num,
    input wire logic [1:0] i_vector_irq_pf,
    input wire logic [2:0] i_vector_irq_traffic_class,
    output logic o_vector_irq_ack,
    output logic o_vector_irq_err,
    // posted write toward the transmit side
    output logic o_tx_valid,
    output logic o_tx_4dw,
    output logic [63:0] o_tx_addr,
    output logic [31:0] o_tx_data,
    output logic [2:0] o_tx_tc,
    input wire logic i_tx_ready
);
    import pig_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // config registers per function
    logic [`PIG_NUM_PF-1:0] dis_q, dis_d, en_q, en_d, fm_q, fm_d;
    logic [31:0] cfg_rdata_q, cfg_rdata_d;

    always_comb begin
        dis_d = dis_q;
        en_d = en_q;
        fm_d = fm_q;
        cfg_rdata_d = 32'h0000_0000;
        if (i_cfg_wr && i_cfg_addr == `PIG_CFG_COMMAND) begin
            dis_d[i_cfg_func] = i_cfg_wdata[`PIG_CMD_INTX_DIS];
        end
        if (i_cfg_wr && i_cfg_addr == `PIG_CFG_MSIX_CTRL) begin
            en_d[i_cfg_func] = i_cfg_wdata[`PIG_MC_ENABLE];
            fm_d[i_cfg_func] = i_cfg_wdata[`PIG_MC_FN_MASK];
        end
        if (i_cfg_rd && i_cfg_addr == `PIG_CFG_COMMAND) begin
            cfg_rdata_d[`PIG_CMD_INTX_DIS] = dis_q[i_cfg_func];
        end
        if (i_cfg_rd && i_cfg_addr == `PIG_CFG_MSIX_CTRL) begin
            // size field is entries minus one, read-only
            cfg_rdata_d = {16'h0000, en_q[i_cfg_func], fm_q[i_cfg_func],
                           3'h0, `PIG_TABLE_SIZE_FIELD};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            dis_q <= '0;
            en_q <= '0;
            fm_q <= '0;
            cfg_rdata_q <= 32'h0000_0000;
        end else begin
            dis_q <= dis_d;
            en_q <= en_d;
            fm_q <= fm_d;
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    assign o_intx_disable = dis_q;
    assign o_msix_enable = en_q;
    assign o_msix_fn_mask = fm_q;
    assign o_cfg_rdata = cfg_rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // legacy messages; one shared pin for both functions
    logic [`PIG_NUM_PF-1:0] lvl_q, lvl_d;
    logic eff, sent_q, ast_q, ast_d, dea_q, dea_d;

    assign eff = |(lvl_q & ~dis_q);

    always_comb begin
        lvl_d = lvl_q;
        lvl_d[i_legacy_irq_function_select] = i_legacy_irq_level_in;
        ast_d = eff && !sent_q;
        dea_d = !eff && sent_q;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            lvl_q <= '0;
            sent_q <= 1'b0;
            ast_q <= 1'b0;
            dea_q <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            sent_q <= eff;
            ast_q <= ast_d;
            dea_q <= dea_d;
        end
    end

    assign o_intx_assert = ast_q;
    assign o_intx_deassert = dea_q;

    ////////////////////////////////////////////////////////////////////////////////
    // host access to table and pending array through bar four only
    logic bar_hit, in_table, in_pba, tab_wr;
    logic [31:0] tab_rdata, mem_rdata_q, mem_rdata_d;
    logic mem_rvalid_q;
    logic [`PIG_NUM_VEC-1:0] pend_q, pend_d, mask_vec;
    logic [`PIG_VEC_W-1:0] cur_q, cur_d;
    logic [63:0] ent_addr;
    logic [31:0] ent_data;
    logic ent_mask;

    assign bar_hit = i_mem_bar == `PIG_MSIX_BAR;
    assign in_table = bar_hit && !i_mem_addr[`PIG_PBA_BIT]
                      && i_mem_addr[`PIG_PBA_BIT-1:`PIG_TABLE_END_LSB] == '0;
    assign in_pba = bar_hit && i_mem_addr[`PIG_PBA_BIT];
    assign tab_wr = i_mem_wr && in_table;

    pig_vec_table u_table (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_wr(tab_wr),
        .i_idx(i_mem_addr[`PIG_ENTRY_SHIFT +: `PIG_VEC_W]),
        .i_dw(i_mem_addr[`PIG_DW_SHIFT +: 2]),
        .i_wdata(i_mem_wdata),
        .o_rdata(tab_rdata),
        .i_ent_idx(cur_q),
        .o_ent_addr(ent_addr),
        .o_ent_data(ent_data),
        .o_ent_mask(ent_mask),
        .o_mask_vec(mask_vec)
    );

    always_comb begin
        mem_rdata_d = 32'h0000_0000;
        if (i_mem_rd && in_table) begin
            mem_rdata_d = tab_rdata;
        end
        // dword zero holds pending bits 0..7; a qword read is dwords zero and one
        if (i_mem_rd && in_pba && i_mem_addr[`PIG_DW_SHIFT +: `PIG_PBA_DW_W] == '0) begin
            mem_rdata_d[`PIG_NUM_VEC-1:0] = pend_q;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            mem_rdata_q <= 32'h0000_0000;
            mem_rvalid_q <= 1'b0;
        end else begin
            mem_rdata_q <= mem_rdata_d;
            mem_rvalid_q <= i_mem_rd;
        end
    end

    assign o_mem_rdata = mem_rdata_q;
    assign o_mem_rvalid = mem_rvalid_q;

    ////////////////////////////////////////////////////////////////////////////////
    // request intake, pending array and message processor
    pig_state_t state_q, state_d;
    logic from_req_q, from_req_d, ack_q, ack_d, err_q, err_d;
    logic tx_valid_q, tx_valid_d, tx_4dw_q, tx_4dw_d;
    logic [63:0] tx_addr_q, tx_addr_d;
    logic [31:0] tx_data_q, tx_data_d;
    logic [2:0] tc_q, tc_d;
    logic req_take, req_bad, bg_ok, bg_any;
    logic [`PIG_VEC_W-1:0] bg_vec;

    // a held request is not taken again in its acknowledge cycle
    assign req_take = i_vector_irq_req && !ack_q && state_q == PIG_IDLE;
    assign req_bad = i_vector_irq_pf > `PIG_PF_LAST || !en_q[i_vector_irq_pf[0]]
                     || fm_q[i_vector_irq_pf[0]];
    assign bg_ok = en_q[0] && !fm_q[0];
    assign bg_any = |(pend_q & ~mask_vec) && bg_ok;

    // lowest pending unmasked vector is retried first
    always_comb begin
        bg_vec = '0;
        for (int v = `PIG_NUM_VEC - 1; v >= 0; v--) begin
            if (pend_q[v] && !mask_vec[v]) begin
                bg_vec = (`PIG_VEC_W)'(v);
            end
        end
    end

    always_comb begin
        state_d = state_q;
        pend_d = pend_q;
        cur_d = cur_q;
        from_req_d = from_req_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        tx_valid_d = tx_valid_q;
        tx_4dw_d = tx_4dw_q;
        tx_addr_d = tx_addr_q;
        tx_data_d = tx_data_q;
        tc_d = tc_q;
        case (state_q)
            PIG_IDLE: begin
                if (req_take && req_bad) begin
                    ack_d = 1'b1;
                    err_d = 1'b1;
                end else if (req_take) begin
                    pend_d[i_vector_irq_num] = 1'b1;
                    cur_d = i_vector_irq_num;
                    tc_d = i_vector_irq_traffic_class;
                    from_req_d = 1'b1;
                    state_d = PIG_FETCH;
                end else if (bg_any) begin
                    cur_d = bg_vec;
                    tc_d = 3'h0;
                    from_req_d = 1'b0;
                    state_d = PIG_FETCH;
                end
            end
            PIG_FETCH: begin
                if (ent_mask) begin
                    ack_d = from_req_q;
                    state_d = PIG_IDLE;
                end else begin
                    tx_valid_d = 1'b1;
                    tx_addr_d = ent_addr;
                    tx_data_d = ent_data;
                    tx_4dw_d = ent_addr[63:32] != 32'h0000_0000;
                    state_d = PIG_SEND;
                end
            end
            PIG_SEND: begin
                if (i_tx_ready) begin
                    tx_valid_d = 1'b0;
                    pend_d[cur_q] = 1'b0;
                    ack_d = from_req_q;
                    state_d = PIG_IDLE;
                end
            end
            default: begin
                state_d = PIG_IDLE;
                tx_valid_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_q <= PIG_IDLE;
            pend_q <= '0;
            cur_q <= '0;
            from_req_q <= 1'b0;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_4dw_q <= 1'b0;
            tx_addr_q <= 64'h0000_0000_0000_0000;
            tx_data_q <= 32'h0000_0000;
            tc_q <= 3'h0;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            cur_q <= cur_d;
            from_req_q <= from_req_d;
            ack_q <= ack_d;
            err_q <= err_d;
            tx_valid_q <= tx_valid_d;
            tx_4dw_q <= tx_4dw_d;
            tx_addr_q <= tx_addr_d;
            tx_data_q <= tx_data_d;
            tc_q <= tc_d;
        end
    end

    assign o_vector_irq_ack = ack_q;
    assign o_vector_irq_err = err_q;
    assign o_tx_valid = tx_valid_q;
    assign o_tx_4dw = tx_4dw_q;
    assign o_tx_addr = tx_addr_q;
    assign o_tx_data = tx_data_q;
    assign o_tx_tc = tc_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    sequence s_req_ok;
        req_take && !req_bad;
    endsequence
    sequence s_tx_done;
        o_tx_valid && i_tx_ready && from_req_q;
    endsequence

    intx_assert_a: assert property (eff && !sent_q |=> o_intx_assert)
        else $error("legacy assert message missing");
    intx_deassert_a: assert property (o_intx_deassert |-> $past(sent_q) && !sent_q)
        else $error("deassert without earlier assert");
    // a new assert two cycles on is legal only after the pin fell in between
    single_assert_a: assert property (o_intx_assert |=> !o_intx_assert
        ##1 (!o_intx_assert || $past(o_intx_deassert)))
        else $error("second assert for shared pin");
    disable_ignore_a: assert property (dis_q[1] && lvl_q[1] && !lvl_q[0]
        |=> !o_intx_assert)
        else $error("disabled function raised assert");
    disable_out_a: assert property (i_cfg_wr && i_cfg_addr == `PIG_CFG_COMMAND
        |=> o_intx_disable[$past(i_cfg_func)] == $past(i_cfg_wdata[`PIG_CMD_INTX_DIS]))
        else $error("interrupt-disable output not updated");
    pend_set_a: assert property (s_req_ok |=> pend_q[$past(i_vector_irq_num)])
        else $error("pending bit not set");
    masked_stays_a: assert property (state_q == PIG_FETCH && ent_mask
        |=> pend_q[$past(cur_q)] && !o_tx_valid)
        else $error("masked vector sent or dropped");
    tx_header_a: assert property (o_tx_valid |-> o_tx_4dw == (o_tx_addr[63:32] != '0))
        else $error("header length wrong");
    ack_after_tx_a: assert property (s_tx_done |=> o_vector_irq_ack && !o_vector_irq_err)
        else $error("acknowledge missing after write");
    err_ack_a: assert property (req_take && req_bad
        |=> o_vector_irq_ack && o_vector_irq_err ##1 !o_vector_irq_ack)
        else $error("error acknowledge missing");
endmodule // pig_irq_gen

/* common/pig_regs.svh */
// offsets, field positions, reset values and sizes of the interrupt generation block
// assumes 32-bit config and memory data paths with dword-aligned byte addresses
`ifndef PIG_REGS_SVH
`define PIG_REGS_SVH

`define PIG_NUM_PF 2
`define PIG_PF_LAST 2'h1
`define PIG_NUM_VEC 8
`define PIG_VEC_W 3
`define PIG_MAX_VEC 2048
`define PIG_TABLE_SIZE_FIELD 11'h007
// config space, per physical function
`define PIG_CFG_COMMAND 12'h004
`define PIG_CMD_INTX_DIS 10
`define PIG_CFG_MSIX_CTRL 12'h050
`define PIG_MC_FN_MASK 14
`define PIG_MC_ENABLE 15
// memory space behind the vector table bar
`define PIG_MSIX_BAR 3'h4
`define PIG_ENTRY_SHIFT 4
`define PIG_DW_SHIFT 2
`define PIG_TABLE_END_LSB 7
`define PIG_PBA_BIT 12
`define PIG_PBA_DW_W 10
// vector table entry layout, dword index and bit positions in the 128-bit entry
`define PIG_DW_ADDR_LO 2'h0
`define PIG_DW_ADDR_HI 2'h1
`define PIG_DW_DATA 2'h2
`define PIG_DW_CTRL 2'h3
`define PIG_ENT_MASK_BIT 96
`define PIG_ENT_RESET 128'h0000_0001_0000_0000_0000_0000_0000_0000

`endif

/* common/pig_pkg.sv */
// types shared by the interrupt generation block
// assumes the constants of pig_regs.svh
package pig_pkg;
    typedef enum logic [1:0] {
        PIG_IDLE,
        PIG_FETCH,
        PIG_SEND
    } pig_state_t;
endpackage

/* hw/pig_vec_table.sv */
// vector table storage: one 128-bit entry of four dwords per vector
// assumes writes come only from the host access decode of the top module
`timescale 1ns/10ps
`include "pig_regs.svh"

module pig_vec_table (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // host dword access
    input wire logic i_wr,
    input wire logic [`PIG_VEC_W-1:0] i_idx,
    input wire logic [1:0] i_dw,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    // processor entry read
    input wire logic [`PIG_VEC_W-1:0] i_ent_idx,
    output logic [63:0] o_ent_addr,
    output logic [31:0] o_ent_data,
    output logic o_ent_mask,
    output logic [`PIG_NUM_VEC-1:0] o_mask_vec
);
    logic [127:0] ent_q [`PIG_NUM_VEC];

    ////////////////////////////////////////////////////////////////////////////////
    // entries, address lo/hi, data, control
    for (genvar e = 0; e < `PIG_NUM_VEC; e++) begin : g_ent
        logic [127:0] ent_d;
        always_comb begin
            ent_d = ent_q[e];
            if (i_wr && i_idx == (`PIG_VEC_W)'(e)) begin
                ent_d[{i_dw, 5'h00} +: 32] = i_wdata;
            end
        end
        always_ff @(posedge i_core_clk) begin
            // vectors come out of reset masked so nothing fires before setup
            if (i_srst) begin
                ent_q[e] <= `PIG_ENT_RESET;
            end else begin
                ent_q[e] <= ent_d;
            end
        end
        assign o_mask_vec[e] = ent_q[e][`PIG_ENT_MASK_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reads
    assign o_rdata = ent_q[i_idx][{i_dw, 5'h00} +: 32];
    assign o_ent_addr = {ent_q[i_ent_idx][{`PIG_DW_ADDR_HI, 5'h00} +: 32],
                         ent_q[i_ent_idx][{`PIG_DW_ADDR_LO, 5'h00} +: 32]};
    assign o_ent_data = ent_q[i_ent_idx][{`PIG_DW_DATA, 5'h00} +: 32];
    assign o_ent_mask = ent_q[i_ent_idx][`PIG_ENT_MASK_BIT];
endmodule // pig_vec_table

/* sim/pig_tx_sink.sv */
// transmit-side model that takes posted writes from the interrupt processor
// assumes one clock shared with the block; stall sets how long ready stays low
`timescale 1ns/10ps

module pig_tx_sink (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // write request
    input wire logic i_valid,
    input wire logic i_4dw,
    input wire logic [63:0] i_addr,
    input wire logic [31:0] i_data,
    input wire logic [2:0] i_tc,
    input wire logic [3:0] i_stall,
    output logic o_ready,
    // capture
    output logic [99:0] o_last,
    output int o_count
);
    int wait_q;

    // ready only while valid, so a stall really keeps the request waiting
    assign o_ready = i_valid && (wait_q >= i_stall);

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            wait_q <= 0;
            o_count <= 0;
        end else if (i_valid && o_ready) begin
            wait_q <= 0;
            o_count <= o_count + 1;
            o_last <= {i_4dw, i_tc, i_addr, i_data};
        end else if (i_valid) begin
            wait_q <= wait_q + 1;
        end
    end
endmodule // pig_tx_sink

/* sim/tb_pcie_interrupt_generation.sv */
// self-checking bench for the legacy and vector interrupt generation block
// assumes the design files and the transmit-side model are compiled first
`timescale 1ns/10ps
`include "pig_regs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb_pcie_interrupt_generation;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic lvl = 1'b0, sel = 1'b0, cwr = 1'b0, crd = 1'b0, cfn = 1'b0;
    logic [11:0] caddr = 12'h000;
    logic [31:0] cwd = 32'h0, crdata, mrdata, mwd = 32'h0, td;
    logic mwr = 1'b0, mrd = 1'b0, mrv, req = 1'b0, ack, err, tv, t4, tr, ast, dea;
    logic [2:0] bar = 3'h4, tc = 3'h0, num = 3'h0, ttc;
    logic [12:0] maddr = 13'h0;
    logic [1:0] pf = 2'h0, idis, men, mfm;
    logic [63:0] ta;
    logic [3:0] stall = 4'h0;
    logic [99:0] last;
    int txn, n_ast = 0, n_dea = 0, n_errors = 0, checks = 0;
    logic [31:0] ent_v [1:2][0:3] = '{'{32'h1000_0040, 32'h0, 32'hA5A5_0001, 32'h0},
                                      '{32'h2000_0080, 32'h1, 32'h5A5A_0002, 32'h0}};

    pig_irq_gen dut (
        .i_core_clk(clk), .i_srst(srst),
        .i_legacy_irq_level_in(lvl), .i_legacy_irq_function_select(sel),
        .o_intx_disable(idis), .o_intx_assert(ast), .o_intx_deassert(dea),
        .o_msix_enable(men), .o_msix_fn_mask(mfm),
        .i_cfg_wr(cwr), .i_cfg_rd(crd), .i_cfg_func(cfn), .i_cfg_addr(caddr),
        .i_cfg_wdata(cwd), .o_cfg_rdata(crdata),
        .i_mem_wr(mwr), .i_mem_rd(mrd), .i_mem_bar(bar), .i_mem_addr(maddr),
        .i_mem_wdata(mwd), .o_mem_rdata(mrdata), .o_mem_rvalid(mrv),
        .i_vector_irq_req(req), .i_vector_irq_num(num), .i_vector_irq_pf(pf),
        .i_vector_irq_traffic_class(tc), .o_vector_irq_ack(ack), .o_vector_irq_err(err),
        .o_tx_valid(tv), .o_tx_4dw(t4), .o_tx_addr(ta), .o_tx_data(td), .o_tx_tc(ttc),
        .i_tx_ready(tr)
    );

    pig_tx_sink sink (
        .i_core_clk(clk), .i_srst(srst), .i_valid(tv), .i_4dw(t4), .i_addr(ta),
        .i_data(td), .i_tc(ttc), .i_stall(stall), .o_ready(tr), .o_last(last),
        .o_count(txn)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // message pulses last one cycle; count them mid-cycle where they are settled
    always @(negedge clk) begin
        if (ast === 1'b1) n_ast++;
        if (dea === 1'b1) n_dea++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cfg_acc(logic w, logic f, logic [11:0] a, logic [31:0] d,
                           output logic [31:0] q);
        tick(1);
        cfn = f;
        caddr = a;
        cwd = d;
        cwr = w;
        crd = !w;
        tick(1);
        cwr = 1'b0;
        crd = 1'b0;
        q = crdata;
    endtask

    task automatic mem_acc(logic w, logic [2:0] b, logic [12:0] a, logic [31:0] d,
                           output logic [31:0] q);
        tick(1);
        bar = b;
        maddr = a;
        mwd = d;
        mwr = w;
        mrd = !w;
        tick(1);
        mwr = 1'b0;
        mrd = 1'b0;
        q = mrdata;
        if (!w) `CHK("mem rvalid", 1'b1, mrv)
    endtask

    // the table base sits at bar offset zero, which is a 4 KB boundary
    function automatic logic [12:0] ent(int n, int dw);
        return 13'(16 * n + 4 * dw);
    endfunction

    task automatic set_lvl(logic f, logic v, int da, int dd);
        int a0, d0;
        tick(1);
        a0 = n_ast;
        d0 = n_dea;
        sel = f;
        lvl = v;
        tick(4);
        `CHK("assert msgs", da, n_ast - a0)
        `CHK("deassert msgs", dd, n_dea - d0)
    endtask

    task automatic vreq(logic [1:0] p, logic [2:0] n, logic [2:0] c, logic e, int ntx);
        int t0, k;
        t0 = txn;
        tick(1);
        pf = p;
        num = n;
        tc = c;
        req = 1'b1;
        for (k = 0; k < 40 && ack !== 1'b1; k++) tick(1);
        `CHK("ack seen", 1'b1, ack)
        `CHK("ack err", e, err)
        req = 1'b0;
        `CHK("writes sent", ntx, txn - t0)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] q;
        `CHK("intx dis rst", 2'b00, idis)
        cfg_acc(1'b0, 1'b0, `PIG_CFG_MSIX_CTRL, 32'h0, q);
        `CHK("msg ctrl rst", {16'h0000, 5'h00, `PIG_TABLE_SIZE_FIELD}, q)
        mem_acc(1'b0, 3'h4, ent(3, 3), 32'h0, q);
        `CHK("vec ctrl rst", 32'h0000_0001, q)
    endtask

    task automatic t_legacy();
        logic [31:0] q;
        set_lvl(1'b0, 1'b1, 1, 0);
        set_lvl(1'b1, 1'b1, 0, 0);
        set_lvl(1'b0, 1'b0, 0, 0);
        set_lvl(1'b1, 1'b0, 0, 1);
        cfg_acc(1'b1, 1'b1, `PIG_CFG_COMMAND, 32'h1 << `PIG_CMD_INTX_DIS, q);
        `CHK("intx dis", 2'b10, idis)
        cfg_acc(1'b0, 1'b1, `PIG_CFG_COMMAND, 32'h0, q);
        `CHK("cmd read", 32'h1 << `PIG_CMD_INTX_DIS, q)
        set_lvl(1'b1, 1'b1, 0, 0);
        set_lvl(1'b1, 1'b0, 0, 0);
        cfg_acc(1'b1, 1'b1, `PIG_CFG_COMMAND, 32'h0, q);
        `CHK("intx dis clr", 2'b00, idis)
    endtask

    task automatic t_table();
        logic [31:0] q;
        for (int n = 1; n <= 2; n++) begin
            for (int d = 0; d < 4; d++) mem_acc(1'b1, 3'h4, ent(n, d), ent_v[n][d], q);
        end
        // a write to entry 1 through the wrong bar; only entry 2 hi, a wrong-bar read and a read past the table are checked after it
        mem_acc(1'b1, 3'h3, ent(1, 1), 32'hFFFF_FFFF, q);
        mem_acc(1'b0, 3'h4, ent(2, 1), 32'h0, q);
        `CHK("entry 2 hi", 32'h0000_0001, q)
        mem_acc(1'b0, 3'h3, ent(2, 1), 32'h0, q);
        `CHK("wrong bar", 32'h0, q)
        mem_acc(1'b0, 3'h4, ent(8, 0), 32'h0, q);
        `CHK("past table", 32'h0, q)
    endtask

    task automatic t_vector();
        logic [31:0] q;
        int t0;
        vreq(2'h0, 3'h3, 3'h0, 1'b1, 0);
        cfg_acc(1'b1, 1'b0, `PIG_CFG_MSIX_CTRL, 32'h1 << `PIG_MC_ENABLE, q);
        `CHK("msix en", 2'b01, men)
        vreq(2'h0, 3'h1, 3'h5, 1'b0, 1);
        `CHK("tx 3dw", {1'b0, 3'h5, 64'h1000_0040, 32'hA5A5_0001}, last)
        stall = 4'h3;
        vreq(2'h0, 3'h2, 3'h2, 1'b0, 1);
        `CHK("tx 4dw", {1'b1, 3'h2, 64'h1_2000_0080, 32'h5A5A_0002}, last)
        vreq(2'h0, 3'h3, 3'h6, 1'b0, 0);
        mem_acc(1'b0, 3'h4, 13'h1000, 32'h0, q);
        `CHK("pending dw0", 32'h0000_0008, q)
        mem_acc(1'b0, 3'h4, 13'h1004, 32'h0, q);
        `CHK("pending dw1", 32'h0, q)
        t0 = txn;
        // unmasking the pending vector lets it go out later, with no acknowledge
        mem_acc(1'b1, 3'h4, ent(3, 3), 32'h0, q);
        tick(10);
        `CHK("late write", 1, txn - t0)
        `CHK("late fields", {1'b0, 3'h0, 64'h0, 32'h0}, last)
        mem_acc(1'b0, 3'h4, 13'h1000, 32'h0, q);
        `CHK("pending clr", 32'h0, q)
        vreq(2'h2, 3'h1, 3'h0, 1'b1, 0);
        cfg_acc(1'b1, 1'b0, `PIG_CFG_MSIX_CTRL, 32'h3 << `PIG_MC_FN_MASK, q);
        `CHK("fn mask", 2'b01, mfm)
        vreq(2'h0, 3'h1, 3'h0, 1'b1, 0);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // the whole sequence needs well under a thousand cycles; this is far beyond it
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_legacy();
        t_table();
        t_vector();
        wrap_up();
    end
endmodule // tb_pcie_interrupt_generation
